// [logic/lane_eq_pkg.sv]
// constants and field layout of the lane equalization preset registers
package lane_eq_pkg;
	// ==========================================================
	// geometry
	localparam int          LANES          = 3;
	localparam int          HALF_W         = 16;
	localparam logic [11:0] ADDR_PAIR_B    = 12'h12C;
	localparam logic [11:0] ADDR_PAIR_C    = 12'h130;
	localparam logic [11:0] ADDR_USER_CTL  = 12'hBC8;
	// register word and half that holds each lane (lane 10, 11, 12 order)
	localparam logic [11:0] LANE_ADDR [LANES] = '{12'h12C, 12'h12C, 12'h130};
	localparam logic        LANE_UPPER[LANES] = '{1'b0, 1'b1, 1'b0};
	// ==========================================================
	// field positions inside one 16-bit lane half
	localparam int DSP_TX_LSB  = 0;
	localparam int DSP_HNT_LSB = 4;
	localparam int USP_TX_LSB  = 8;
	localparam int USP_HNT_LSB = 12;
	localparam int PRESET_W    = 4;
	localparam int HINT_W      = 3;
	// user lane control word: lane select and the two presets to load
	localparam int USER_LANE_LSB = 0;
	localparam int USER_LANE_W   = 2;
	localparam int USER_DSP_LSB  = 4;
	localparam int USER_USP_LSB  = 8;
	// link control 2 transmit margin bits 9:7, bit 8 is index 1
	localparam int XLINK_BIT     = 1;
	// ==========================================================
	// reset values
	localparam logic [3:0] USP_TX_RESET  = 4'hF;
	localparam logic [2:0] USP_HNT_RESET = 3'h7;
	localparam logic [3:0] DSP_TX_RESET  = 4'h0;
	localparam logic [2:0] DSP_HNT_RESET = 3'h0;
endpackage : lane_eq_pkg

// [logic/lane_eq_if.sv]
// signals between the register top and one lane's field block
`timescale 1ns/100ps
interface lane_eq_if;
	import lane_eq_pkg::*;
	logic                is_dsp;       // port is downstream
	logic                xlink_dis;    // cross-link disabled
	logic                phase1;       // equalization phase 1 active
	logic                send_eq;      // sending eq ts2s before gen3 change
	logic                wr_en;        // load path write to this half
	logic [HALF_W-1:0]   wdata;        // half word to load
	logic                user_ld;      // user control load to this lane
	logic [PRESET_W-1:0] user_dsp_tx;  // downstream preset to load
	logic [PRESET_W-1:0] user_usp_tx;  // upstream preset to load
	logic                rx_valid;     // eq ts2 received on the lane
	logic [PRESET_W-1:0] rx_preset;    // received transmit preset
	logic [HINT_W-1:0]   rx_hint;      // received receiver hint
	logic [HALF_W-1:0]   half;         // read view of the lane half
	logic [PRESET_W-1:0] tx_drive;     // preset driven on transmitters
	logic                ts2_valid;    // eq ts2 being sent
	logic [PRESET_W-1:0] ts2_preset;   // preset carried in sent ts2
	logic [HINT_W-1:0]   ts2_hint;     // hint carried in sent ts2
	modport top  (output is_dsp, xlink_dis, phase1, send_eq, wr_en, wdata, user_ld,
		user_dsp_tx, user_usp_tx, rx_valid, rx_preset, rx_hint,
		input half, tx_drive, ts2_valid, ts2_preset, ts2_hint);
	modport lane (input is_dsp, xlink_dis, phase1, send_eq, wr_en, wdata, user_ld,
		user_dsp_tx, user_usp_tx, rx_valid, rx_preset, rx_hint,
		output half, tx_drive, ts2_valid, ts2_preset, ts2_hint);
endinterface : lane_eq_if

// [logic/lane_eq_field.sv]
// preset and hint fields of one lane
`timescale 1ns/100ps
module lane_eq_field
	import lane_eq_pkg::*;
(
	input  wire logic i_clock,   // 10 MHz clock
	input  wire logic i_rstn,    // async reset, active low
	input  wire logic i_clk_en,  // freezes state while low
	lane_eq_if.lane   lif        // lane side of the carrier
);
	typedef struct packed {
		logic                init_q;
		logic [PRESET_W-1:0] dsp_tx_q;
		logic [HINT_W-1:0]   dsp_hint_q;
		logic [PRESET_W-1:0] usp_tx_q;
		logic [HINT_W-1:0]   usp_hint_q;
		logic [PRESET_W-1:0] drive_q;
		logic                ts2_vld_q;
		logic [PRESET_W-1:0] ts2_pre_q;
		logic [HINT_W-1:0]   ts2_hint_q;
	} lane_state_t;

	lane_state_t s_q;
	lane_state_t s_d;

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		// [R10] downstream clears
		if (!s_q.init_q) begin
			s_d.init_q = 1'b1;
			if (lif.is_dsp) begin
				s_d.usp_tx_q   = DSP_TX_RESET;
				s_d.usp_hint_q = DSP_HNT_RESET;
			end
		end
		if (lif.is_dsp) begin
			if (lif.wr_en) begin
				s_d.dsp_tx_q   = lif.wdata[DSP_TX_LSB +: PRESET_W];
				s_d.dsp_hint_q = lif.wdata[DSP_HNT_LSB +: HINT_W];
				s_d.usp_tx_q   = lif.wdata[USP_TX_LSB +: PRESET_W];
				s_d.usp_hint_q = lif.wdata[USP_HNT_LSB +: HINT_W];
			end
			// [R2] user control load
			if (lif.user_ld) begin
				s_d.dsp_tx_q = lif.user_dsp_tx;
				s_d.usp_tx_q = lif.user_usp_tx;
			end
			// [R3] store partner hint
			if (lif.rx_valid) begin
				s_d.dsp_hint_q = lif.rx_hint;
			end
		end else if (lif.xlink_dis && lif.rx_valid) begin
			// [R4] capture upstream preset
			s_d.usp_tx_q   = lif.rx_preset;
			// [R5] capture upstream hint
			s_d.usp_hint_q = lif.rx_hint;
		end
		// [R1] phase 1 drive
		s_d.drive_q    = (lif.is_dsp && lif.phase1) ? s_q.dsp_tx_q : DSP_TX_RESET;
		// [R7] send in eq ts2
		s_d.ts2_vld_q  = lif.is_dsp && lif.send_eq;
		s_d.ts2_pre_q  = s_q.usp_tx_q;
		// [R9] sent hint reflected
		s_d.ts2_hint_q = s_q.usp_hint_q;
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			s_q            <= '0;
			// [R10] upstream fields all ones
			s_q.usp_tx_q   <= USP_TX_RESET;
			s_q.usp_hint_q <= USP_HNT_RESET;
		end else if (i_clk_en) begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// read view, downstream-only fields read zero on an upstream port
	// [R13] reserved bits zero
	assign lif.half = {1'b0, s_q.usp_hint_q, s_q.usp_tx_q, 1'b0,
		(lif.is_dsp ? s_q.dsp_hint_q : DSP_HNT_RESET),
		(lif.is_dsp ? s_q.dsp_tx_q : DSP_TX_RESET)};
	assign lif.tx_drive   = s_q.drive_q;
	assign lif.ts2_valid  = s_q.ts2_vld_q;
	assign lif.ts2_preset = s_q.ts2_pre_q;
	assign lif.ts2_hint   = s_q.ts2_hint_q;
endmodule : lane_eq_field

// [logic/lane_equalization_preset_regs.sv]
// lane equalization preset register words for lanes 10, 11 and 12
//
// Function
// [R1] A downstream port drives each lane transmitter with its downstream preset in phase 1.
// [R2] The downstream presets can be loaded by the user lane control word at offset BC8h.
// [R3] On a downstream port the partner's received hint is stored in the downstream hint field but never used.
// [R4] An upstream port with cross-link off captures the received ts2 preset.
// [R5] An upstream port with cross-link off captures the received ts2 hint.
// [R6] Cross-link is on unless bit 8 of the link control 2 transmit margin is clear.
// [R7] A downstream port sends the upstream preset field in eq ts2s before the gen3 change.
// [R8] The partner adopts the preset it received as its transmitter preset at gen3.
// [R9] On a downstream port the upstream hint field is the hint sent on the lane.
// [R10] Upstream fields reset to all ones, downstream fields to zero; a downstream port clears its upstream fields to zero one cycle after reset.
// [R11] Lane 11 sits in the upper half of lane_pair_eq_control_b and lane 12 in the lower half of lane_pair_eq_control_c.
// [R12] Lane 10 sits in the lower half of lane_pair_eq_control_b.
// [R13] Reserved bits read zero and are preserved; fields are sticky.
`timescale 1ns/100ps
module lane_equalization_preset_regs
	import lane_eq_pkg::*;
(
	input  wire logic                           i_clock,            // 10 MHz clock
	input  wire logic                           i_rstn,             // async reset, low
	input  wire logic                           i_clk_en,           // state freeze when low
	input  wire logic                           i_is_downstream,    // port is downstream
	input  wire logic                           i_is_mgmt_port,     // port may take user ctl
	input  wire logic [2:0]                     i_link_tx_margin,   // link ctl 2 bits 9:7
	input  wire logic [11:0]                    i_reg_addr,         // register byte offset
	input  wire logic                           i_reg_wr,           // write strobe
	input  wire logic                           i_reg_rd,           // read strobe
	input  wire logic [31:0]                    i_reg_wdata,        // write data
	input  wire logic                           i_eq_phase1,        // eq phase 1 active
	input  wire logic                           i_send_eq_ts2,      // rcvrcfg before gen3
	input  wire logic [LANES-1:0]               i_rx_ts2_valid,     // eq ts2 received
	input  wire logic [LANES-1:0][PRESET_W-1:0] i_rx_ts2_preset,    // received preset
	input  wire logic [LANES-1:0][HINT_W-1:0]   i_rx_ts2_hint,      // received hint
	output logic      [31:0]                    o_reg_rdata,        // read data
	output logic                                o_reg_ack,          // read/write done pulse
	output logic      [LANES-1:0][PRESET_W-1:0] o_tx_preset,        // transmitter preset
	output logic      [LANES-1:0]               o_tx_ts2_valid,     // eq ts2 sent
	output logic      [LANES-1:0][PRESET_W-1:0] o_tx_ts2_preset,    // preset in sent ts2
	output logic      [LANES-1:0][HINT_W-1:0]   o_tx_ts2_hint       // hint in sent ts2
);
	typedef struct packed {
		logic [31:0] rdata_q;
		logic        ack_q;
	} bus_state_t;

	bus_state_t               s_q;
	bus_state_t               s_d;
	logic [LANES-1:0][HALF_W-1:0] half;
	logic                     xlink_dis;
	logic                     user_wr;

	// ==========================================================
	// port mode
	// [R6] cross-link default on
	assign xlink_dis = ~i_link_tx_margin[XLINK_BIT];
	// [R2] user control decode
	assign user_wr = i_reg_wr && i_is_mgmt_port && (i_reg_addr == ADDR_USER_CTL);

	// ==========================================================
	// lane blocks
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			lane_eq_if lif ();
			assign lif.is_dsp      = i_is_downstream;
			assign lif.xlink_dis   = xlink_dis;
			assign lif.phase1      = i_eq_phase1;
			assign lif.send_eq     = i_send_eq_ts2;
			// [R11] lane to half mapping
			// [R12] lane 10 lower half
			assign lif.wr_en = i_reg_wr && (i_reg_addr == LANE_ADDR[g]);
			assign lif.wdata = LANE_UPPER[g] ? i_reg_wdata[31:16] : i_reg_wdata[15:0];
			assign lif.user_ld = user_wr &&
				(i_reg_wdata[USER_LANE_LSB +: USER_LANE_W] == USER_LANE_W'(g));
			assign lif.user_dsp_tx = i_reg_wdata[USER_DSP_LSB +: PRESET_W];
			assign lif.user_usp_tx = i_reg_wdata[USER_USP_LSB +: PRESET_W];
			assign lif.rx_valid    = i_rx_ts2_valid[g];
			assign lif.rx_preset   = i_rx_ts2_preset[g];
			assign lif.rx_hint     = i_rx_ts2_hint[g];
			assign half[g]            = lif.half;
			assign o_tx_preset[g]     = lif.tx_drive;
			assign o_tx_ts2_valid[g]  = lif.ts2_valid;
			assign o_tx_ts2_preset[g] = lif.ts2_preset;
			assign o_tx_ts2_hint[g]   = lif.ts2_hint;
			lane_eq_field u_field (
				.i_clock  (i_clock),
				.i_rstn   (i_rstn),
				.i_clk_en (i_clk_en),
				.lif      (lif)
			);
		end
	endgenerate

	// ==========================================================
	// read path
	always_comb begin
		s_d       = s_q;
		s_d.ack_q = i_reg_rd || i_reg_wr;
		if (i_reg_rd) begin
			// [R11] word assembly
			if (i_reg_addr == ADDR_PAIR_B) begin
				s_d.rdata_q = {half[1], half[0]};
			end else if (i_reg_addr == ADDR_PAIR_C) begin
				s_d.rdata_q = {16'h0000, half[2]};
			end else begin
				s_d.rdata_q = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			s_q <= '0;
		end else if (i_clk_en) begin
			s_q <= s_d;
		end
	end

	assign o_reg_rdata = s_q.rdata_q;
	assign o_reg_ack   = s_q.ack_q;
endmodule : lane_equalization_preset_regs

// [sim/lane_eq_properties.sv]
// assertions on the lane equalization preset register ports
`timescale 1ns/100ps
module lane_eq_properties
	import lane_eq_pkg::*;
(
	input	wire logic				i_clock,	// clock
	input	wire logic				i_rstn,	// reset, low
	input	wire logic				i_clk_en,	// run
	input	wire logic				i_is_downstream,	// downstream port
	input	wire logic				i_eq_phase1,	// phase 1
	input	wire logic				i_send_eq_ts2,	// send eq ts2
	input	wire logic [11:0]			i_reg_addr,	// offset
	input	wire logic				i_reg_rd,	// read
	input	wire logic				i_reg_wr,	// write
	input	wire logic [31:0]			o_reg_rdata,	// read data
	input	wire logic				o_reg_ack,	// ack
	input	wire logic [LANES-1:0][PRESET_W-1:0]	o_tx_preset,	// tx preset
	input	wire logic [LANES-1:0]			o_tx_ts2_valid	// ts2 sent
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);
	property p_ack; i_clk_en && (i_reg_rd || i_reg_wr) |=> o_reg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_noack; i_clk_en && !(i_reg_rd || i_reg_wr) |=> !o_reg_ack; endproperty
	a_noack: assert property (p_noack) else $error("stray ack");
	property p_ts2v; i_clk_en && i_is_downstream && i_send_eq_ts2 |=> &o_tx_ts2_valid; endproperty
	a_ts2v: assert property (p_ts2v) else $error("ts2 not sent");
	property p_ts2off; i_clk_en && !i_send_eq_ts2 |=> o_tx_ts2_valid == '0; endproperty
	a_ts2off: assert property (p_ts2off) else $error("ts2 sent late");
	property p_txup; i_clk_en && !i_is_downstream |=> o_tx_preset == '0; endproperty
	a_txup: assert property (p_txup) else $error("upstream tx preset");
	property p_txph; i_clk_en && !i_eq_phase1 |=> o_tx_preset == '0; endproperty
	a_txph: assert property (p_txph) else $error("tx preset off phase");
	property p_rsvd; o_reg_ack |-> (o_reg_rdata & 32'h8080_8080) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_upper; i_clk_en && i_reg_rd && i_reg_addr == ADDR_PAIR_C |=>
		o_reg_rdata[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper half set");
endmodule : lane_eq_properties
bind lane_equalization_preset_regs lane_eq_properties u_props (.i_clock(i_clock),
	.i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_is_downstream(i_is_downstream),
	.i_eq_phase1(i_eq_phase1), .i_send_eq_ts2(i_send_eq_ts2), .i_reg_addr(i_reg_addr),
	.i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
	.o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_tx_preset(o_tx_preset),
	.o_tx_ts2_valid(o_tx_ts2_valid));

// [sim/eq_link_partner.sv]
// downstream link partner model on the equalization lanes
`timescale 1ns/100ps
module eq_link_partner
	import lane_eq_pkg::*;
(
	input	wire logic				i_clock,	// clock
	input	wire logic				i_rstn,	// reset, low
	input	wire logic [LANES-1:0]			i_go,	// send eq ts2
	input	wire logic [PRESET_W-1:0]		i_preset,	// preset to send
	input	wire logic [HINT_W-1:0]			i_hint,	// hint to send
	input	wire logic [LANES-1:0]			i_ts2_valid,	// ts2 from port
	input	wire logic [LANES-1:0][PRESET_W-1:0]	i_ts2_preset,	// its preset
	output	logic [LANES-1:0]			o_valid,	// ts2 to port
	output	logic [LANES-1:0][PRESET_W-1:0]		o_preset,	// preset sent
	output	logic [LANES-1:0][HINT_W-1:0]		o_hint,	// hint sent
	output	logic [LANES-1:0][PRESET_W-1:0]		o_adopted	// own tx preset
);
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_valid <= '0;
			o_preset <= '0;
			o_hint <= '0;
			o_adopted <= '0;
		end else begin
			o_valid <= i_go;
			for (int g = 0; g < LANES; g++) begin
				// idle lanes toggle so no stale value looks valid
				o_preset[g] <= i_go[g] ? i_preset : ~o_preset[g];
				o_hint[g] <= i_go[g] ? i_hint : ~o_hint[g];
				if (i_ts2_valid[g])
					o_adopted[g] <= i_ts2_preset[g];
			end
		end
	end
endmodule : eq_link_partner

// [sim/lane_equalization_preset_regs_tb.sv]
// self-checking bench for the lane equalization preset registers
`timescale 1ns/100ps
module lane_equalization_preset_regs_tb;
	import lane_eq_pkg::*;
	logic				i_clock, i_rstn, is_ds, phase1, send_eq, rd, wr, ack;
	logic				clk_en, mgmt;
	logic [2:0]			margin;
	logic [11:0]			addr;
	logic [31:0]			wdata, rdata;
	logic [LANES-1:0]		go, rxv, txv;
	logic [PRESET_W-1:0]		p_pre;
	logic [HINT_W-1:0]		p_hnt;
	logic [LANES-1:0][PRESET_W-1:0]	rxp, txp, ts2p, adopted;
	logic [LANES-1:0][HINT_W-1:0]	rxh, ts2h;
	int				error_cnt = 0;
	int				comparisons = 0;
	lane_equalization_preset_regs DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(clk_en),
		.i_is_downstream(is_ds), .i_is_mgmt_port(mgmt), .i_link_tx_margin(margin),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
		.i_eq_phase1(phase1), .i_send_eq_ts2(send_eq), .i_rx_ts2_valid(rxv),
		.i_rx_ts2_preset(rxp), .i_rx_ts2_hint(rxh), .o_reg_rdata(rdata), .o_reg_ack(ack),
		.o_tx_preset(txp), .o_tx_ts2_valid(txv), .o_tx_ts2_preset(ts2p), .o_tx_ts2_hint(ts2h));
	eq_link_partner partner (.i_clock(i_clock), .i_rstn(i_rstn), .i_go(go), .i_preset(p_pre),
		.i_hint(p_hnt), .i_ts2_valid(txv), .i_ts2_preset(ts2p), .o_valid(rxv),
		.o_preset(rxp), .o_hint(rxh), .o_adopted(adopted));
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clock) #1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge i_clock) #1;
		wr = 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge i_clock) #1;
		addr = a;
		rd = 1'b1;
		@(posedge i_clock) #1;
		rd = 1'b0;
		chk({31'h0, ack}, 32'h1);
		chk(rdata, exp);
	endtask : reg_rd
	task automatic send(input logic [LANES-1:0] l, input logic [3:0] p, input logic [2:0] h);
		@(posedge i_clock) #1;
		go = l;
		p_pre = p;
		p_hnt = h;
		@(posedge i_clock) #1;
		go = '0;
	endtask : send
	task automatic do_reset(input logic ds);
		i_rstn = 1'b0;
		is_ds = ds;
		repeat (12) @(posedge i_clock);
		#1 i_rstn = 1'b1;
	endtask : do_reset
	task automatic results;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results
	initial begin
		{phase1, send_eq, rd, wr, go, p_pre, p_hnt, addr, wdata} = '0;
		margin = 3'h7;
		clk_en = 1'b1;
		mgmt = 1'b1;
		do_reset(1'b1);
		reg_rd(ADDR_PAIR_B, 32'h0);
		reg_wr(ADDR_PAIR_B, 32'hFFFF_FFFF);
		reg_rd(ADDR_PAIR_B, 32'h7F7F_7F7F);
		reg_wr(ADDR_PAIR_C, 32'hFFFF_FFFF);
		reg_rd(ADDR_PAIR_C, 32'h0000_7F7F);
		reg_wr(ADDR_USER_CTL, 32'h0000_0952);
		reg_rd(ADDR_PAIR_C, 32'h0000_7975);
		phase1 = 1'b1;
		repeat (2) @(posedge i_clock);
		#1 chk({20'h0, txp}, {20'h0, 12'h5FF});
		phase1 = 1'b0;
		send_eq = 1'b1;
		repeat (2) @(posedge i_clock);
		#1 chk({8'h0, txv, ts2p, ts2h}, {8'h0, 3'h7, 12'h9FF, 9'h1FF});
		chk({20'h0, adopted}, {20'h0, 12'h9FF});
		send_eq = 1'b0;
		send(3'b001, 4'h4, 3'h2);
		reg_rd(ADDR_PAIR_B, 32'h7F7F_7F2F);
		// user control refused off the management port
		mgmt = 1'b0;
		reg_wr(ADDR_USER_CTL, 32'h0000_0341);
		reg_rd(ADDR_PAIR_B, 32'h7F7F_7F2F);
		// a strobe while the clock enable is low is not taken
		@(posedge i_clock) #1 clk_en = 1'b0;
		reg_wr(ADDR_PAIR_B, 32'h0);
		chk({31'h0, ack}, 32'h0);
		clk_en = 1'b1;
		reg_rd(ADDR_PAIR_B, 32'h7F7F_7F2F);
		mgmt = 1'b1;
		reg_wr(ADDR_USER_CTL, 32'h0000_0341);
		reg_rd(ADDR_PAIR_B, 32'h7374_7F2F);
		do_reset(1'b0);
		reg_rd(ADDR_PAIR_B, 32'h7F00_7F00);
		reg_wr(ADDR_PAIR_B, 32'h0);
		reg_rd(ADDR_PAIR_B, 32'h7F00_7F00);
		send(3'b111, 4'h3, 3'h1);
		reg_rd(ADDR_PAIR_C, 32'h0000_7F00);
		margin = 3'h5;
		send(3'b111, 4'h3, 3'h1);
		reg_rd(ADDR_PAIR_B, 32'h1300_1300);
		reg_rd(ADDR_PAIR_C, 32'h0000_1300);
		reg_rd(12'h134, 32'h0);
		results();
	end
endmodule : lane_equalization_preset_regs_tb
